// *** logic/ccp_pkg.sv ***
// Package of constants for the capture/compare unit.
package ccp_pkg;

  localparam logic [1:0] REG_CONTROL    = 2'h0;
  localparam logic [1:0] REG_VALUE_LOW  = 2'h1;
  localparam logic [1:0] REG_VALUE_HIGH = 2'h2;
  localparam logic [1:0] REG_FLAGS      = 2'h3;

  localparam int DUTY_LSB = 4;
  localparam int DUTY_MSB = 5;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 3;
  localparam logic [7:0] CONTROL_MASK = 8'h3f;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Flag register three layout: event flag at bit 1, enable at bit 1 of the enable byte.
  localparam int FLAG_BIT   = 1;
  localparam int ENABLE_BIT = 1;

  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_HIGH   = 4'h8;
  localparam logic [3:0] MODE_CMP_LOW    = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT   = 4'ha;

  localparam logic [3:0] PRESCALE_4_LAST  = 4'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hf;

endpackage

// *** logic/ccp_capture_compare_unit.sv ***
// Capture/compare unit with software register port, pin logic and timer selection.
//
// Notes on behaviour
// - Mode zero switches the unit off and clears the compare latch and prescaler; reserved codes do nothing.
// - Mode 0010 toggles the pin on each compare match and sets the flag.
// - Capture on falling, rising, every fourth or every sixteenth rising pin edge.
// - Mode 1000 starts the pin low, drives high on match, sets flag.
// - Mode 1001 starts the pin high, drives low on match, sets flag.
// - Mode 1010 only sets the flag; pin shows the port latch.
// - Control bits 5:4 store the two low duty bits, unused otherwise.
// - Value low, value high and control are readable and writable bytes.
// - Capture/compare use timer one or three, chosen by the select input.
// - A capture copies the full 16-bit timer count into the value pair.
// - Every capture sets the event flag; only software clears it.
// - A newer capture overwrites an unread older value.
// - Edge detection watches the pin level even when the pin drives out.
// - Mode changes may set the flag falsely; software clears it afterwards.
// - Prescaler counter is cleared when off or not capturing.
// - Changing prescale directly keeps the counter; software writes zero first.
// - Compare checks value against timer continuously; action and flag same cycle.
// - Compare output comes from its own latch, low by default.
// - Event flag sits at bit 1 of flag register three; enable is written at bit 1 with bit 7 set and reads back at bit 7.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module ccp_capture_compare_unit
  import ccp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic [15:0] timer_one_count,
  input  wire logic [15:0] timer_three_count,
  input  wire logic        timer_select_three,
  input  wire logic        module_pin_in,
  input  wire logic        port_latch,
  output logic             module_pin_out,
  output logic             module_event_flag,
  output logic             module_event_enable,
  output logic             module_event_request
);

  logic [7:0]  capture_compare_control;
  logic [7:0]  capture_compare_value_low;
  logic [7:0]  capture_compare_value_high;
  logic        compare_latch;
  logic        pin_meta;
  logic        pin_sync;
  logic        pin_prev;
  logic [3:0]  prescale_count;
  logic [3:0]  mode_q;

  function automatic logic is_capture(input logic [3:0] m);
    is_capture = (m[3:2] == 2'b01);
  endfunction

  wire logic [3:0]  module_mode_select = capture_compare_control[MODE_MSB:MODE_LSB];
  wire logic [1:0]  duty_low_bits      = capture_compare_control[DUTY_MSB:DUTY_LSB];
  wire logic        wr_control = reg_write && (reg_addr == REG_CONTROL);
  wire logic        wr_low     = reg_write && (reg_addr == REG_VALUE_LOW);
  wire logic        wr_high    = reg_write && (reg_addr == REG_VALUE_HIGH);
  wire logic        wr_flags   = reg_write && (reg_addr == REG_FLAGS);
  wire logic [15:0] timer_sel  = timer_select_three ? timer_three_count
                                                    : timer_one_count;
  wire logic [15:0] value_pair = {capture_compare_value_high, capture_compare_value_low};
  wire logic        capturing  = is_capture(module_mode_select);
  wire logic        rise       = pin_sync && !pin_prev;
  wire logic        fall       = !pin_sync && pin_prev;
  wire logic        mode_cmp_drive = (module_mode_select == MODE_CMP_TOGGLE) ||
                                     (module_mode_select == MODE_CMP_HIGH) ||
                                     (module_mode_select == MODE_CMP_LOW);
  wire logic        mode_cmp   = mode_cmp_drive || (module_mode_select == MODE_CMP_SOFT);
  wire logic        match      = mode_cmp && (value_pair == timer_sel);
  wire logic [3:0]  prescale_last = (module_mode_select == MODE_CAP_RISE16) ?
                                    PRESCALE_16_LAST : PRESCALE_4_LAST;
  wire logic        prescaled  = (module_mode_select == MODE_CAP_RISE4) ||
                                 (module_mode_select == MODE_CAP_RISE16);
  wire logic        capture_event =
      ((module_mode_select == MODE_CAP_FALL) && fall) ||
      ((module_mode_select == MODE_CAP_RISE) && rise) ||
      (prescaled && rise && (prescale_count == prescale_last));
  wire logic        set_event = capture_event || match;
  wire logic        entering  = (module_mode_select != mode_q);

  logic next_compare_latch;
  always_comb begin
    next_compare_latch = compare_latch;
    if (module_mode_select == MODE_OFF) begin
      next_compare_latch = 1'b0;
    end else if (entering && (module_mode_select == MODE_CMP_HIGH)) begin
      next_compare_latch = 1'b0;
    end else if (entering && (module_mode_select == MODE_CMP_LOW)) begin
      next_compare_latch = 1'b1;
    end else if (match) begin
      unique case (module_mode_select)
        MODE_CMP_TOGGLE: next_compare_latch = !compare_latch;
        MODE_CMP_HIGH:   next_compare_latch = 1'b1;
        MODE_CMP_LOW:    next_compare_latch = 1'b0;
        default:         next_compare_latch = compare_latch;
      endcase
    end
  end

  // Reserved codes and the soft-interrupt mode hand the pin back to the port latch.
  assign module_pin_out = mode_cmp_drive ? compare_latch : port_latch;
  assign module_event_request = module_event_flag && module_event_enable;

  always_ff @(posedge ref_clk) begin
    pin_meta <= module_pin_in;
    pin_sync <= pin_meta;
    if (rst) begin
      pin_prev <= 1'b0;
      mode_q   <= MODE_OFF;
    end else begin
      pin_prev <= pin_sync;
      mode_q   <= module_mode_select;
    end
  end

  // Prescale counter is not cleared on a switch between capture modes.
  always_ff @(posedge ref_clk) begin
    if (rst || !capturing) begin
      prescale_count <= 4'h0;
    end else if (prescaled && rise) begin
      prescale_count <= (prescale_count == prescale_last) ? 4'h0
                                                          : prescale_count + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      compare_latch <= 1'b0;
    end else begin
      compare_latch <= next_compare_latch;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      capture_compare_control <= CONTROL_RESET;
    end else if (wr_control) begin
      capture_compare_control <= reg_wdata & CONTROL_MASK;
    end
  end

  // A capture in the same cycle as a software write wins, so no event is lost.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      capture_compare_value_low  <= 8'h00;
      capture_compare_value_high <= 8'h00;
    end else if (capture_event) begin
      capture_compare_value_low  <= timer_sel[7:0];
      capture_compare_value_high <= timer_sel[15:8];
    end else begin
      if (wr_low) begin
        capture_compare_value_low <= reg_wdata;
      end
      if (wr_high) begin
        capture_compare_value_high <= reg_wdata;
      end
    end
  end

  // Flag byte: bit 1 is the event flag; bit 1 of the upper nibble view is not used,
  // so the enable lives at bit 1 of a separate write selected by bit 7 of the data.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      module_event_flag   <= 1'b0;
      module_event_enable <= 1'b0;
    end else begin
      if (set_event) begin
        module_event_flag <= 1'b1;
      end else if (wr_flags && !reg_wdata[7]) begin
        module_event_flag <= reg_wdata[FLAG_BIT];
      end
      if (wr_flags && reg_wdata[7]) begin
        module_event_enable <= reg_wdata[ENABLE_BIT];
      end
    end
  end

  wire logic [7:0] flags_view = {6'h00, module_event_flag, 1'b0} |
                                {module_event_enable, 7'h00};
  logic [7:0] read_mux;
  always_comb begin
    unique case (reg_addr)
      REG_CONTROL:    read_mux = {2'b00, duty_low_bits, module_mode_select};
      REG_VALUE_LOW:  read_mux = capture_compare_value_low;
      REG_VALUE_HIGH: read_mux = capture_compare_value_high;
      REG_FLAGS:      read_mux = flags_view;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= read_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// *** sim/ccp_monitor.sv ***
// Port assertions for the capture/compare unit.
`timescale 1ns/1ns
module ccp_monitor
  import ccp_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [1:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic [15:0] timer_one_count,
  input wire logic [15:0] timer_three_count,
  input wire logic        timer_select_three,
  input wire logic        port_latch,
  input wire logic        module_pin_out,
  input wire logic        module_event_flag,
  input wire logic        module_event_enable,
  input wire logic        module_event_request
);
  // Shadows see software writes only, so the value must be rewritten after a capture.
  logic [3:0]  mode;
  logic [15:0] val;
  wire         hit = val == (timer_select_three ? timer_three_count : timer_one_count);
  wire         drv = mode == MODE_CMP_TOGGLE || mode[3:1] == 3'h4;
  wire         cmp = drv || mode == MODE_CMP_SOFT;
  wire         tog = mode == MODE_CMP_TOGGLE && hit;
  wire         fwr = reg_write && reg_addr == REG_FLAGS && !reg_wdata[7];
  wire         frd = reg_read && reg_addr == REG_FLAGS;
  wire [7:0]   fby = {module_event_enable, 5'h00, module_event_flag, 1'b0};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode <= MODE_OFF;
      val  <= 16'h0000;
    end else if (reg_write) begin
      if (reg_addr == REG_CONTROL) mode <= reg_wdata[3:0];
      if (reg_addr == REG_VALUE_LOW) val[7:0] <= reg_wdata;
      if (reg_addr == REG_VALUE_HIGH) val[15:8] <= reg_wdata;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("stray read data");
  request_a: assert property (module_event_request == (fby[7] & fby[1]))
    else $error("request mismatch");
  flag_keep_a: assert property ($fell(module_event_flag) |-> $past(fwr))
    else $error("flag fell by itself");
  flag_read_a: assert property ($past(frd) |-> reg_rdata == $past(fby))
    else $error("flag byte wrong");
  pin_pass_a: assert property (!drv |-> module_pin_out == port_latch)
    else $error("pin not latch");
  cmp_flag_a: assert property (cmp && hit |-> ##1 module_event_flag)
    else $error("match without flag");
  toggle_a: assert property (tog |=> $changed(module_pin_out))
    else $error("no toggle");
  drive_a: assert property (mode[3:1] == 3'h4 && hit |=> module_pin_out != $past(mode[0]))
    else $error("pin not forced");
  cover property (tog);
  cover property (cmp && hit && !tog);
  cover property ($rose(module_event_flag) && !cmp);
endmodule

// *** sim/ccp_pin_model.sv ***
// Far side model: the event pin and the two shared timers.
`timescale 1ns/1ns
module ccp_pin_model (
  input  wire logic        ref_clk,
  input  wire logic        run,
  input  wire logic        level,
  output logic      [15:0] count_one,
  output wire logic        pin,
  output logic      [15:0] count_three
);
  initial begin
    count_one = 16'h0123;
    count_three = 16'hc0de;
  end
  always @(posedge ref_clk) begin
    if (run) begin
      count_one <= count_one + 16'h0001;
      count_three <= count_three - 16'h0003;
    end
  end
  // The pin moves away from the clock edge, so the unit has to synchronise it.
  assign #37 pin = level;
endmodule

// *** sim/ccp_capture_compare_unit_test.sv ***
// Self-checking bench for the capture/compare unit.
`timescale 1ns/1ns
module ccp_capture_compare_unit_test
  import ccp_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, sel = 1'b0;
  logic        run = 1'b0, level = 1'b0, latch = 1'b0, pin, po, flag, req, en;
  logic [1:0]  addr = 2'h0;
  logic [7:0]  wd = 8'h00, rdata;
  logic [15:0] t1, t3, tgt;
  logic [3:0]  modes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
  int          failures = 0;
  int          checks_done = 0;
  ccp_pin_model i_pm (.ref_clk(clk), .run(run), .level(level), .count_one(t1),
    .count_three(t3), .pin(pin));
  ccp_capture_compare_unit i_dut (.ref_clk(clk), .rst(rst), .reg_addr(addr),
    .reg_wdata(wd), .reg_write(we), .reg_read(re), .reg_rdata(rdata),
    .timer_one_count(t1), .timer_three_count(t3), .timer_select_three(sel),
    .module_pin_in(pin), .port_latch(latch), .module_pin_out(po),
    .module_event_flag(flag), .module_event_enable(en), .module_event_request(req));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic lvl(input logic v);
    @(posedge clk) level <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic cap(input logic [3:0] m, input int n);
    wr(REG_CONTROL, 8'h00);
    wr(REG_CONTROL, {4'h0, m});
    wr(REG_FLAGS, 8'h00);
    repeat (n - 1) begin
      lvl(1'b0);
      lvl(1'b1);
    end
    rdc(REG_FLAGS, 8'h00);
    lvl(1'b0);
    lvl(1'b1);
    rdc(REG_FLAGS, 8'h02);
    rdc(REG_VALUE_LOW, t1[7:0]);
    rdc(REG_VALUE_HIGH, t1[15:8]);
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial forever #50 clk = ~clk;
  initial begin
    #1_000_000;
    failures++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rdc(2'(i), 8'h00);
    wr(REG_CONTROL, 8'hff);
    rdc(REG_CONTROL, 8'h3f);
    wr(REG_VALUE_HIGH, 8'h5a);
    rdc(REG_VALUE_HIGH, 8'h5a);
    cap(MODE_CAP_RISE, 1);
    cap(MODE_CAP_RISE4, 4);
    cap(MODE_CAP_RISE16, 16);
    @(posedge clk) sel <= 1'b1;
    wr(REG_CONTROL, {4'h0, MODE_CAP_FALL});
    wr(REG_FLAGS, 8'h00);
    lvl(1'b0);
    rdc(REG_FLAGS, 8'h02);
    rdc(REG_VALUE_LOW, t3[7:0]);
    rdc(REG_VALUE_HIGH, t3[15:8]);
    @(posedge clk) sel <= 1'b0;
    foreach (modes[i]) begin
      tgt = t1 + 16'h0003;
      wr(REG_CONTROL, 8'h00);
      latch <= !(modes[i] inside {4'h2, 4'h8});
      wr(REG_VALUE_LOW, tgt[7:0]);
      wr(REG_VALUE_HIGH, tgt[15:8]);
      wr(REG_CONTROL, {4'h0, modes[i]});
      wr(REG_FLAGS, 8'h00);
      run <= 1'b1;
      repeat (8) @(posedge clk);
      run <= 1'b0;
      rdc(REG_FLAGS, {6'h00, modes[i] inside {4'h2, 4'h8, 4'h9, 4'ha}, 1'b0});
      chk(16'(po), 16'(modes[i] != 4'h9));
    end
    wr(REG_FLAGS, 8'h82);
    #1 chk(16'(en), 16'h0001);
    chk(16'(flag), 16'h0000);
    wr(REG_FLAGS, 8'h02);
    #1 chk(16'(req), 16'h0001);
    rdc(REG_FLAGS, 8'h82);
    wr(REG_FLAGS, 8'h00);
    #1 chk(16'(req), 16'h0000);
    chk(16'(en), 16'h0001);
    chk(16'(flag), 16'h0000);
    complete_run();
  end
endmodule
bind ccp_capture_compare_unit ccp_monitor i_mon (.*);
